// ==== hdl/mtr_pkg.sv ====
package mtr_pkg;

	// slave address 101 0010
	localparam logic [6:0]  MTR_I2C_ADDR       = 7'h52;

	// timing
	localparam int          MTR_CLK_NS         = 100;
	localparam int          MTR_PERIOD_UNIT_NS = 10000;
	localparam int          MTR_TICK_CYCLES    = (MTR_PERIOD_UNIT_NS + MTR_CLK_NS - 1) / MTR_CLK_NS;
	localparam logic [6:0]  MTR_TICK_LAST      = 7'(MTR_TICK_CYCLES - 1);

	// speed in 0.1 Hz = 1e6 / period in 10 us units
	localparam logic [19:0] MTR_SPEED_NUM      = 20'h f4240;
	localparam logic [4:0]  MTR_DIV_STEPS      = 5'h14;

	// register offsets
	localparam logic [7:0]  MTR_CTRL_LAST      = 8'h03;
	localparam logic [7:0]  MTR_STATUS         = 8'h10;
	localparam logic [7:0]  MTR_SPEED_HI       = 8'h11;
	localparam logic [7:0]  MTR_PERIOD_HI      = 8'h13;
	localparam logic [7:0]  MTR_EMF_HI         = 8'h15;
	localparam logic [7:0]  MTR_CURRENT_HI     = 8'h17;
	localparam logic [7:0]  MTR_ANGLE          = 8'h19;
	localparam logic [7:0]  MTR_VCC            = 8'h1a;
	localparam logic [7:0]  MTR_CMD_RATE       = 8'h1b;
	localparam logic [7:0]  MTR_APPLIED_DUTY   = 8'h1c;
	localparam logic [7:0]  MTR_FAULT          = 8'h1e;
	localparam logic [7:0]  MTR_NVM_FIRST      = 8'h20;
	localparam logic [7:0]  MTR_NVM_LAST       = 8'h2b;
	localparam logic [7:0]  MTR_UNMAPPED       = 8'h00;

	// two-byte quantities: speed, period, emf constant, current
	localparam int          MTR_PAIRS          = 4;
	localparam logic [7:0]  MTR_PAIR_HI [0:3]  = '{8'h11, 8'h13, 8'h15, 8'h17};

	// field positions
	localparam int          MTR_OVERRIDE_BIT   = 7;
	localparam int          MTR_NVM_ADV_IDX    = 3;
	localparam int          MTR_ADV_LSB        = 4;

	// start angle codes
	localparam logic [7:0]  MTR_SECTOR [0:5]   = '{8'h00, 8'h2b, 8'h55, 8'h80, 8'hab, 8'hd5};
	localparam logic [7:0]  MTR_ADVANCE [0:3]  = '{8'h16, 8'h2c, 8'h3f, 8'h55};

	// nonvolatile image reset values
	localparam logic [7:0]  MTR_NVM_RESET [0:11] = '{8'h4a, 8'h4e, 8'h2a, 8'h00, 8'h98, 8'he4,
		8'h7a, 8'hf4, 8'h69, 8'hb8, 8'h00, 8'h00};

	typedef enum logic [2:0] {
		MTR_IDLE, MTR_ADDR, MTR_ADDR_ACK, MTR_WR, MTR_WR_ACK, MTR_RD, MTR_RD_ACK
	} mtr_i2c_e;

endpackage

// ==== hdl/mtr_i2c_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface mtr_i2c_if;
	logic       wr_stb;
	logic       wr_first;
	logic [7:0] wr_data;
	logic       rd_stb;
	logic [7:0] rd_data;
	modport link (output wr_stb, output wr_first, output wr_data, output rd_stb, input rd_data);
	modport regs (input wr_stb, input wr_first, input wr_data, input rd_stb, output rd_data);
endinterface
`default_nettype wire

// ==== hdl/mtr_i2c_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
module mtr_i2c_slave
	import mtr_pkg::*;
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// serial pins
	input  wire logic scl_in,
	input  wire logic sda_in,
	output var  logic sda_drive_n,
	// byte side
	mtr_i2c_if.link   bus
);
	mtr_i2c_e   state;
	logic       scl_q, sda_q, scl_p, sda_p;
	logic [3:0] bitcnt;
	logic [7:0] shreg;
	logic       is_read;
	logic       first_byte;

	wire        scl_rise   = scl_q & ~scl_p;
	wire        scl_fall   = ~scl_q & scl_p;
	wire        start_seen = scl_q & scl_p & sda_p & ~sda_q;
	wire        stop_seen  = scl_q & scl_p & ~sda_p & sda_q;
	wire [7:0]  shifted    = {shreg[6:0], sda_q};
	wire        addr_hit   = shreg[7:1] == MTR_I2C_ADDR;
	wire        byte_full  = bitcnt == 4'h8;
	wire [7:0]  load_bits  = {bus.rd_data[6:0], 1'b1};

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
			scl_p <= scl_q;
			sda_p <= sda_q;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state       <= MTR_IDLE;
			bitcnt      <= 4'h0;
			shreg       <= 8'h00;
			is_read     <= 1'b0;
			first_byte  <= 1'b0;
			sda_drive_n <= 1'b1;
			bus.wr_stb  <= 1'b0;
			bus.wr_first <= 1'b0;
			bus.wr_data <= 8'h00;
			bus.rd_stb  <= 1'b0;
		end else begin
			bus.wr_stb <= 1'b0;
			bus.rd_stb <= 1'b0;
			if (start_seen) begin
				state       <= MTR_ADDR;
				bitcnt      <= 4'h0;
				sda_drive_n <= 1'b1;
			end else if (stop_seen) begin
				state       <= MTR_IDLE;
				sda_drive_n <= 1'b1;
			end else begin
				case (state)
					MTR_ADDR: begin
						if (scl_rise && !byte_full) begin
							shreg  <= shifted;
							bitcnt <= bitcnt + 4'h1;
						end else if (scl_fall && byte_full) begin
							// other addresses are left alone until the next start
							if (addr_hit) begin
								state       <= MTR_ADDR_ACK;
								sda_drive_n <= 1'b0;
								is_read     <= shreg[0];
								first_byte  <= 1'b1;
							end else begin
								state <= MTR_IDLE;
							end
						end
					end
					MTR_ADDR_ACK, MTR_RD_ACK: begin
						if (scl_rise) begin
							if (state == MTR_RD_ACK && sda_q) begin
								state <= MTR_IDLE;
							end else if (is_read) begin
								bus.rd_stb <= 1'b1;
							end
						end else if (scl_fall) begin
							if (is_read) begin
								state       <= MTR_RD;
								sda_drive_n <= bus.rd_data[7];
								shreg       <= load_bits;
								bitcnt      <= 4'h1;
							end else begin
								state       <= MTR_WR;
								sda_drive_n <= 1'b1;
								bitcnt      <= 4'h0;
							end
						end
					end
					MTR_WR: begin
						if (scl_rise && !byte_full) begin
							shreg  <= shifted;
							bitcnt <= bitcnt + 4'h1;
						end else if (scl_fall && byte_full) begin
							state        <= MTR_WR_ACK;
							sda_drive_n  <= 1'b0;
							bus.wr_stb   <= 1'b1;
							bus.wr_data  <= shreg;
							bus.wr_first <= first_byte;
							first_byte   <= 1'b0;
						end
					end
					MTR_WR_ACK: begin
						if (scl_fall) begin
							state       <= MTR_WR;
							sda_drive_n <= 1'b1;
							bitcnt      <= 4'h0;
						end
					end
					MTR_RD: begin
						if (scl_fall) begin
							if (byte_full) begin
								state       <= MTR_RD_ACK;
								sda_drive_n <= 1'b1;
							end else begin
								sda_drive_n <= shreg[7];
								shreg       <= {shreg[6:0], 1'b1};
								bitcnt      <= bitcnt + 4'h1;
							end
						end
					end
					MTR_IDLE: begin
						sda_drive_n <= 1'b1;
					end
					default: begin
						state <= MTR_IDLE;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ==== hdl/mtr_regbank.sv ====
// Contract
// - speed is a 16-bit value in 0.1 Hz units split over a high and a low byte register.
// - speed refreshes by itself while spinning, from the phase U zero-crossing interval.
// - reading a high byte copies the live low byte into a shadow that the low byte read returns.
// - every two-register status quantity uses the snapshot readback scheme; the control speed setting does not.
// - the 16-bit electrical period in 10 us units is measured between phase U crossings.
// - back-EMF is integrated over a half cycle and stored once per electrical cycle.
// - after the start-position sense the detected rotor position is stored in a byte.
// - the position byte is sector code plus advance code modulo 256.
// - the supply is sampled during operation and held as an 8-bit reading.
// - the active speed input is converted into one readable 8-bit command value.
// - the applied duty byte shows the buffered command actually driven.
// - the block answers only at 7-bit address 1010010.
// - control 0x00-0x03, status 0x10-0x1E and nonvolatile 0x20-0x2B are decoded.
`timescale 1ns/1ps
`default_nettype none
module mtr_regbank
	import mtr_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// serial pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output var  logic        sda_out,
	output var  logic        sda_drive_n,
	// motor sensing
	input  wire logic        motor_spinning,
	input  wire logic        zc_u_rise,
	input  wire logic        zc_u_fall,
	input  wire logic        bemf_valid,
	input  wire logic [7:0]  bemf_sample,
	input  wire logic        ipd_done,
	input  wire logic [2:0]  ipd_sector,
	input  wire logic        vcc_valid,
	input  wire logic [7:0]  vcc_sample,
	input  wire logic        current_valid,
	input  wire logic [10:0] phase_current,
	// speed command sources
	input  wire logic        pwm_mode,
	input  wire logic [7:0]  pwm_duty,
	input  wire logic [7:0]  analog_level,
	input  wire logic [7:0]  applied_duty_in,
	// flags from the protection logic
	input  wire logic [3:0]  status_flags,
	input  wire logic [5:0]  fault_flags,
	// settings out
	output var  logic [8:0]  speed_setting,
	output var  logic        speed_override,
	output var  logic [7:0]  nvm_control,
	output var  logic [7:0]  commanded_rate_value
);
	mtr_i2c_if bus ();

	mtr_i2c_slave u_slave (
		.core_clk    (core_clk),
		.rst_n       (rst_n),
		.scl_in      (scl_in),
		.sda_in      (sda_in),
		.sda_drive_n (sda_drive_n),
		.bus         (bus.link)
	);

	logic [7:0]  ptr;
	logic [7:0]  ctrl_reg [0:3];
	logic [7:0]  nvm_image [0:11];
	logic [15:0] speed_val, period_val, emf_val, current_val;
	logic [7:0]  start_rotor_angle;
	logic [7:0]  vcc_level_reading;
	logic [7:0]  applied_duty_value;
	logic [6:0]  tick_cnt;
	logic [15:0] period_cnt;
	logic        integrating;
	logic [15:0] emf_acc;
	logic        div_busy;
	logic [4:0]  div_cnt;
	logic [15:0] div_den;
	logic [16:0] div_rem;
	logic [19:0] div_quo;

	// register decode
	wire        is_ctrl   = ptr <= MTR_CTRL_LAST;
	wire        is_nvm    = ptr >= MTR_NVM_FIRST && ptr <= MTR_NVM_LAST;
	wire [7:0]  nvm_ofs   = ptr - MTR_NVM_FIRST;
	wire [3:0]  nvm_idx   = nvm_ofs[3:0];
	wire [7:0]  next_ptr  = ptr + 8'h01;
	wire        ctrl_wr   = bus.wr_stb && !bus.wr_first && is_ctrl;
	wire        nvm_wr    = bus.wr_stb && !bus.wr_first && is_nvm;

	// two-byte quantities with one shadow each
	wire [15:0] pair_live [0:MTR_PAIRS-1];
	wire [7:0]  pair_acc  [0:MTR_PAIRS];
	logic [7:0] low_byte_shadow [0:MTR_PAIRS-1];
	logic       pair_hit;

	assign pair_live[0] = speed_val;
	assign pair_live[1] = period_val;
	assign pair_live[2] = emf_val;
	assign pair_live[3] = current_val;
	assign pair_acc[0]  = 8'h00;

	genvar gi;
	generate
		for (gi = 0; gi < MTR_PAIRS; gi++) begin : g_pair
			wire hi_sel = ptr == MTR_PAIR_HI[gi];
			wire lo_sel = ptr == MTR_PAIR_HI[gi] + 8'h01;
			wire [7:0] word = hi_sel ? pair_live[gi][15:8] :
				lo_sel ? low_byte_shadow[gi] : 8'h00;
			assign pair_acc[gi+1] = pair_acc[gi] | word;
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					low_byte_shadow[gi] <= 8'h00;
				end else if (bus.rd_stb && hi_sel) begin
					low_byte_shadow[gi] <= pair_live[gi][7:0];
				end
			end
		end
	endgenerate

	// readback selection, holes and gaps read as zero
	assign pair_hit = (ptr >= MTR_SPEED_HI) && (ptr <= MTR_CURRENT_HI + 8'h01);
	wire [7:0] rd_mux =
		is_ctrl                  ? ctrl_reg[ptr[1:0]] :
		is_nvm                   ? nvm_image[nvm_idx] :
		ptr == MTR_STATUS        ? {status_flags, 4'h0} :
		pair_hit                 ? pair_acc[MTR_PAIRS] :
		ptr == MTR_ANGLE         ? start_rotor_angle :
		ptr == MTR_VCC           ? vcc_level_reading :
		ptr == MTR_CMD_RATE      ? commanded_rate_value :
		ptr == MTR_APPLIED_DUTY  ? applied_duty_value :
		ptr == MTR_FAULT         ? {2'h0, fault_flags} :
		MTR_UNMAPPED;

	// pointer and writable registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr          <= 8'h00;
			bus.rd_data  <= 8'h00;
		end else if (bus.wr_stb && bus.wr_first) begin
			ptr <= bus.wr_data;
		end else if (bus.wr_stb || bus.rd_stb) begin
			ptr <= next_ptr;
			if (bus.rd_stb) begin
				bus.rd_data <= rd_mux;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				ctrl_reg[i] <= 8'h00;
			end
			for (int i = 0; i < 12; i++) begin
				nvm_image[i] <= MTR_NVM_RESET[i];
			end
		end else if (ctrl_wr) begin
			ctrl_reg[ptr[1:0]] <= bus.wr_data;
		end else if (nvm_wr) begin
			nvm_image[nvm_idx] <= bus.wr_data;
		end
	end

	assign speed_setting  = {ctrl_reg[1][0], ctrl_reg[0]};
	assign speed_override = ctrl_reg[1][MTR_OVERRIDE_BIT];
	assign nvm_control    = ctrl_reg[3];
	assign sda_out        = 1'b0;

	// period in 10 us ticks between phase U crossings
	wire tick = tick_cnt == MTR_TICK_LAST;
	wire zc_take = zc_u_rise && motor_spinning;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt   <= 7'h00;
			period_cnt <= 16'h0000;
			period_val <= 16'h0000;
		end else if (!motor_spinning) begin
			tick_cnt   <= 7'h00;
			period_cnt <= 16'h0000;
		end else begin
			tick_cnt <= tick ? 7'h00 : tick_cnt + 7'h01;
			if (zc_take) begin
				period_val <= period_cnt;
				period_cnt <= 16'h0000;
			end else if (tick && period_cnt != 16'hffff) begin
				period_cnt <= period_cnt + 16'h0001;
			end
		end
	end

	// speed = constant / period, a single serial divider used only for speed saves a wide array
	wire [16:0] div_try  = {div_rem[15:0], div_quo[19]};
	wire        div_fits = div_try >= {1'b0, div_den};
	wire [16:0] div_sub  = div_try - {1'b0, div_den};
	wire        div_sat  = div_quo[19:16] != 4'h0;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_busy  <= 1'b0;
			div_cnt   <= 5'h00;
			div_den   <= 16'h0000;
			div_rem   <= 17'h00000;
			div_quo   <= 20'h00000;
			speed_val <= 16'h0000;
		end else if (zc_take && period_cnt != 16'h0000) begin
			div_busy <= 1'b1;
			div_cnt  <= MTR_DIV_STEPS;
			div_den  <= period_cnt;
			div_rem  <= 17'h00000;
			div_quo  <= MTR_SPEED_NUM;
		end else if (div_busy) begin
			div_rem <= div_fits ? div_sub : div_try;
			div_quo <= {div_quo[18:0], div_fits};
			div_cnt <= div_cnt - 5'h01;
			if (div_cnt == 5'h00) begin
				div_busy  <= 1'b0;
				speed_val <= div_sat ? 16'hffff : div_quo[15:0];
			end
		end
	end

	// back-emf integral over the first half of each cycle
	wire [16:0] emf_sum = {1'b0, emf_acc} + {9'h000, bemf_sample};

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			integrating <= 1'b0;
			emf_acc     <= 16'h0000;
			emf_val     <= 16'h0000;
		end else if (zc_take) begin
			integrating <= 1'b1;
			emf_acc     <= 16'h0000;
		end else if (integrating && zc_u_fall) begin
			integrating <= 1'b0;
			emf_val     <= emf_acc;
		end else if (integrating && bemf_valid) begin
			emf_acc <= emf_sum[16] ? 16'hffff : emf_sum[15:0];
		end
	end

	// start angle, supply, current and command bytes
	wire [1:0] adv_sel   = nvm_image[MTR_NVM_ADV_IDX][MTR_ADV_LSB +: 2];
	wire [7:0] sector_cd = ipd_sector > 3'h5 ? MTR_SECTOR[0] : MTR_SECTOR[ipd_sector];
	wire [7:0] angle_sum = sector_cd + MTR_ADVANCE[adv_sel];
	wire [7:0] next_cmd  = speed_override ? speed_setting[8:1] :
		pwm_mode ? pwm_duty : analog_level;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			start_rotor_angle    <= 8'h00;
			vcc_level_reading    <= 8'h00;
			current_val          <= 16'h0000;
			commanded_rate_value <= 8'h00;
			applied_duty_value   <= 8'h00;
		end else begin
			if (ipd_done) begin
				start_rotor_angle <= angle_sum;
			end
			if (vcc_valid) begin
				vcc_level_reading <= vcc_sample;
			end
			if (current_valid) begin
				current_val <= {5'h00, phase_current};
			end
			commanded_rate_value <= next_cmd;
			applied_duty_value   <= applied_duty_in;
		end
	end
endmodule
`default_nettype wire

// ==== tb/mtr_regbank_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module mtr_regbank_monitor (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       rst_n,
	// serial pins
	input wire logic       scl_in,
	input wire logic       sda_out,
	input wire logic       sda_drive_n,
	// command path
	input wire logic       pwm_mode,
	input wire logic [7:0] pwm_duty,
	input wire logic [7:0] analog_level,
	input wire logic [8:0] speed_setting,
	input wire logic       speed_override,
	input wire logic [7:0] nvm_control,
	input wire logic [7:0] commanded_rate_value
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	chk_cmd_pwm: assert property (
		$past(rst_n) && !$past(speed_override) && $past(pwm_mode)
		|-> commanded_rate_value == $past(pwm_duty))
		else $error("command does not follow pwm duty");
	chk_cmd_analog: assert property (
		$past(rst_n) && !$past(speed_override) && !$past(pwm_mode)
		|-> commanded_rate_value == $past(analog_level))
		else $error("command does not follow analog level");
	chk_cmd_override: assert property (
		$past(rst_n) && $past(speed_override)
		|-> {1'b0, commanded_rate_value} == ($past(speed_setting) >> 1))
		else $error("command does not follow bus setting");
	chk_sda_pull_low: assert property (
		sda_out == 1'b0)
		else $error("sda driven high");
	chk_drive_start_low: assert property (
		$fell(sda_drive_n) |-> !scl_in)
		else $error("sda drive began with scl high");
	chk_drive_end_low: assert property (
		$rose(sda_drive_n) |-> !scl_in)
		else $error("sda drive ended with scl high");
	// a change while scl is high would read as start or stop
	chk_drive_hold_high: assert property (
		scl_in && $past(scl_in) |-> $stable(sda_drive_n))
		else $error("sda drive moved while scl high");
	chk_reset_state: assert property (
		$rose(rst_n) |-> sda_drive_n && speed_setting == 9'h000
		&& !speed_override && nvm_control == 8'h00)
		else $error("control outputs not at reset value");
endmodule
`default_nettype wire

// ==== tb/mtr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mtr_host_model
	import mtr_pkg::*;
(
	// clock
	input  wire logic core_clk,
	// bus pins, 1 releases to the pull-up
	output var  logic scl_o,
	output var  logic sda_o,
	input  wire logic sda_wire
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// long wait before scl rises lets the slave drop its ack first
	task automatic start();
		sda_o = 1'b1;
		w(8);
		scl_o = 1'b1;
		w(8);
		sda_o = 1'b0;
		w(8);
		scl_o = 1'b0;
	endtask
	task automatic stop();
		w(4);
		sda_o = 1'b0;
		w(4);
		scl_o = 1'b1;
		w(8);
		sda_o = 1'b1;
		w(8);
	endtask
	task automatic bit_io(input logic b, output logic r);
		w(4);
		sda_o = b;
		w(4);
		scl_o = 1'b1;
		w(4);
		r = sda_wire;
		w(4);
		scl_o = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic ack_n);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(last, ack_n);
	endtask
	task automatic write_reg(input logic [7:0] dev, input logic [7:0] ptr,
		input logic [7:0] data, output logic nak);
		logic [7:0] q;
		logic       a0;
		logic       a1;
		logic       a2;
		start();
		xfer(dev, 1'b1, q, a0);
		xfer(ptr, 1'b1, q, a1);
		xfer(data, 1'b1, q, a2);
		stop();
		nak = a0 | a1 | a2;
	endtask
	// one byte per read, so a pair is read high byte first
	task automatic read_reg(input logic [7:0] ptr, output logic [7:0] q);
		logic [7:0] x;
		logic       a;
		start();
		xfer({MTR_I2C_ADDR, 1'b0}, 1'b1, x, a);
		xfer(ptr, 1'b1, x, a);
		start();
		xfer({MTR_I2C_ADDR, 1'b1}, 1'b1, x, a);
		xfer(8'hff, 1'b1, q, a);
		stop();
	endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
	import mtr_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        motor_spinning = 1'b0, zc_u_rise = 1'b0, zc_u_fall = 1'b0;
	logic        bemf_valid = 1'b0, ipd_done = 1'b0, vcc_valid = 1'b0;
	logic        current_valid = 1'b0, pwm_mode = 1'b1;
	logic [2:0]  ipd_sector = 3'h0;
	logic [3:0]  status_flags = 4'ha;
	logic [5:0]  fault_flags = 6'h2d;
	logic [7:0]  bemf_sample = 8'h10, vcc_sample = 8'hb7, pwm_duty = 8'h5a;
	logic [7:0]  analog_level = 8'hc3, applied_duty_in = 8'h77;
	logic [10:0] phase_current = 11'h5a3;
	wire logic   scl_in, sda_in, sda_out, sda_drive_n, sda_host, speed_override;
	wire logic [8:0] speed_setting;
	wire logic [7:0] nvm_control, commanded_rate_value;
	int          fail_count = 0, compares = 0;
	int          sec [6] = '{0, 43, 85, 128, 171, 213};
	int          adv [4] = '{22, 44, 63, 85};
	localparam logic [7:0] dev_w = {MTR_I2C_ADDR, 1'b0};

	// open drain wire with pull-up
	assign sda_in = sda_host & (sda_drive_n | sda_out);
	always #50 core_clk = ~core_clk;

	mtr_host_model u_host (.core_clk, .scl_o(scl_in), .sda_o(sda_host), .sda_wire(sda_in));
	mtr_regbank u_dut (.core_clk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_drive_n,
		.motor_spinning, .zc_u_rise, .zc_u_fall, .bemf_valid, .bemf_sample, .ipd_done,
		.ipd_sector, .vcc_valid, .vcc_sample, .current_valid, .phase_current, .pwm_mode,
		.pwm_duty, .analog_level, .applied_duty_in, .status_flags, .fault_flags,
		.speed_setting, .speed_override, .nvm_control, .commanded_rate_value);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] q;
		u_host.read_reg(a, q);
		check({8'h00, q}, {8'h00, exp});
	endtask
	task automatic wr(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] d,
		input logic nak);
		logic n;
		u_host.write_reg(dev, a, d, n);
		check({15'h0000, n}, {15'h0000, nak});
	endtask
	// rising crossings ticks*100 cycles apart, five samples per half cycle
	task automatic cycle_u(input int ticks);
		zc_u_rise = 1'b1;
		@(negedge core_clk);
		zc_u_rise = 1'b0;
		repeat (5) begin
			@(negedge core_clk);
			bemf_valid = 1'b1;
			@(negedge core_clk);
			bemf_valid = 1'b0;
		end
		zc_u_fall = 1'b1;
		@(negedge core_clk);
		zc_u_fall = 1'b0;
		repeat (ticks * 100 - 12) @(negedge core_clk);
	endtask
	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge core_clk);
		fail_count++;
		stop_test();
	end

	initial begin
		repeat (4) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (2) @(negedge core_clk);
		for (int i = 0; i < 12; i++) rd(8'h20 + 8'(i), MTR_NVM_RESET[i]);
		rd(8'h1d, 8'h00);
		wr(8'ha6, 8'h00, 8'h55, 1'b1);
		rd(8'h00, 8'h00);
		rd(MTR_STATUS, 8'ha0);
		fault_flags = 6'h12;
		rd(MTR_FAULT, 8'h12);
		$display("test map done");
		rd(MTR_CMD_RATE, 8'h5a);
		pwm_mode = 1'b0;
		rd(MTR_CMD_RATE, 8'hc3);
		wr(dev_w, 8'h00, 8'h34, 1'b0);
		wr(dev_w, 8'h01, 8'h81, 1'b0);
		check({7'h00, speed_setting}, 16'h0134);
		check({15'h0000, speed_override}, 16'h0001);
		rd(MTR_CMD_RATE, 8'h9a);
		wr(dev_w, 8'h03, 8'h5c, 1'b0);
		check({8'h00, nvm_control}, 16'h005c);
		rd(8'h03, 8'h5c);
		wr(dev_w, MTR_CMD_RATE, 8'hee, 1'b0);
		rd(MTR_CMD_RATE, 8'h9a);
		rd(MTR_APPLIED_DUTY, 8'h77);
		vcc_valid = 1'b1;
		@(negedge core_clk);
		vcc_valid = 1'b0;
		rd(MTR_VCC, 8'hb7);
		$display("test command done");
		for (int s = 0; s < 6; s++) begin
			wr(dev_w, 8'h23, 8'(s % 4) << 4, 1'b0);
			ipd_sector = 3'(s);
			ipd_done = 1'b1;
			@(negedge core_clk);
			ipd_done = 1'b0;
			rd(MTR_ANGLE, 8'(sec[s] + adv[s % 4]));
		end
		$display("test angle done");
		motor_spinning = 1'b1;
		current_valid = 1'b1;
		@(negedge core_clk);
		current_valid = 1'b0;
		cycle_u(25);
		cycle_u(25);
		rd(8'h11, 8'h9c);
		rd(8'h12, 8'h40);
		rd(8'h13, 8'h00);
		rd(8'h14, 8'h19);
		rd(8'h15, 8'h00);
		rd(8'h16, 8'h50);
		rd(8'h17, 8'h05);
		rd(8'h18, 8'ha3);
		// high bytes now, live values move, then low bytes
		rd(8'h11, 8'h9c);
		rd(8'h13, 8'h00);
		cycle_u(50);
		cycle_u(50);
		rd(8'h12, 8'h40);
		rd(8'h14, 8'h19);
		rd(8'h11, 8'h4e);
		rd(8'h12, 8'h20);
		rd(8'h13, 8'h00);
		rd(8'h14, 8'h32);
		motor_spinning = 1'b0;
		cycle_u(30);
		cycle_u(30);
		rd(8'h13, 8'h00);
		rd(8'h14, 8'h32);
		$display("test motor done");
		stop_test();
	end
endmodule

bind mtr_regbank mtr_regbank_monitor u_mon (.core_clk, .rst_n, .scl_in, .sda_out,
	.sda_drive_n, .pwm_mode, .pwm_duty, .analog_level, .speed_setting, .speed_override,
	.nvm_control, .commanded_rate_value);
`default_nettype wire
